// ===== logic/snr_receiver.sv
// Purpose: receive side of a single-edge nibble link
// Assumes: sensor drives falling-edge coded frames on line_in
// Notes:   frame word is right justified, status nibble first
//
// How it works
// - runs as receiver only while bit 15 and receive_select bit 11 are both one
// - edge spacing inside 16-bit lower and upper limits starts a frame
// - accepted sync length stored, tick period derived from it
// - later intervals checked against nibble width, data stored high/low
// - a completion pulse marks each complete message that does not fail the hardware CRC check
// - bits 2 to 0 give one to six data nibbles per frame
// - bit 8 picks hardware CRC check or leaves it to software
// - bit 7 set means a pause pulse follows and is expected
`include "snr_map.svh"
module snr_receiver
    import snr_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // sensor line
    input  wire logic                  line_in,
    // configuration
    input  wire logic [15:0]           control_one,
    input  wire logic [`SNR_CNT_W-1:0] upper_limit_reg,
    input  wire logic [`SNR_CNT_W-1:0] lower_limit_reg,
    // results
    output logic [`SNR_CNT_W-1:0]      sync_capture,
    output logic [`SNR_CNT_W-1:0]      tick_period,
    output snr_frame_t                 frame_data_high_low,
    output logic                       message_done,
    output logic                       nibble_error,
    output logic                       crc_error,
    output logic                       frame_active
);
    localparam logic [`SNR_CNT_W-1:0] CNT_MAX = '1;
    localparam logic [`SNR_TICK_W-1:0] TICK_MAX = '1;

    logic       fall;
    logic       enable;
    logic       hw_crc;
    logic       pause_on;
    logic [2:0] nib_n;
    logic [2:0] last_idx;

    snr_state_t             state;
    snr_state_t             next_state;
    logic [`SNR_CNT_W-1:0]  ivl;
    logic [`SNR_CNT_W-1:0]  next_ivl;
    logic [`SNR_CNT_W-1:0]  phase;
    logic [`SNR_CNT_W-1:0]  next_phase;
    logic [`SNR_TICK_W-1:0] ticks;
    logic [`SNR_TICK_W-1:0] next_ticks;
    logic [2:0]             nib_idx;
    logic [2:0]             next_nib_idx;
    logic [27:0]            shift;
    logic [27:0]            next_shift;
    logic [3:0]             crc;
    logic [3:0]             next_crc;
    logic [3:0]             val;
    logic [3:0]             crc_final;
    logic                   nib_ok;
    logic                   sync_ok;
    logic [`SNR_CNT_W-1:0]  next_sync_capture;
    logic [`SNR_CNT_W-1:0]  next_tick_period;
    logic [`SNR_CNT_W-1:0]  tick_raw;
    snr_frame_t             next_frame;
    logic                   next_done;
    logic                   next_nib_err;
    logic                   next_crc_err;

    snr_edge_sync u_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .line_in (line_in),
        .fall    (fall)
    );

    // ------------------------------------------------------------
    // crc step, augmented division one nibble at a time
    // ------------------------------------------------------------
    function automatic logic [3:0] crc_step(input logic [3:0] c,
                                            input logic [3:0] n);
        logic [3:0] r;
        logic       fb;
        r = c;
        for (int i = 3; i >= 0; i--) begin
            fb = r[3];
            r  = {r[2:0], n[i]};
            if (fb) begin
                r = r ^ `SNR_CRC_POLY;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    always_comb begin
        enable   = control_one[`SNR_ON_BIT] & control_one[`SNR_RCV_BIT];
        hw_crc   = control_one[`SNR_CRC_BIT];
        pause_on = control_one[`SNR_PPP_BIT];
        nib_n    = control_one[`SNR_NIB_MSB:`SNR_NIB_LSB];
        if (nib_n < `SNR_NIB_LO) begin
            nib_n = `SNR_NIB_LO;
        end else if (nib_n > `SNR_NIB_HI) begin
            nib_n = `SNR_NIB_HI;
        end
        last_idx = nib_n + 3'h1;
    end

    // ------------------------------------------------------------
    // receive engine
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_ivl          = (ivl == CNT_MAX) ? ivl : ivl + 1'b1;
        next_phase        = phase + 1'b1;
        next_ticks        = ticks;
        next_nib_idx      = nib_idx;
        next_shift        = shift;
        next_crc          = crc;
        next_sync_capture = sync_capture;
        next_tick_period  = tick_period;
        next_frame        = frame_data_high_low;
        next_done         = 1'b0;
        next_nib_err      = 1'b0;
        next_crc_err      = 1'b0;
        tick_raw          = ivl >> `SNR_SYNC_SHIFT;
        sync_ok = (ivl >= lower_limit_reg) && (ivl <= upper_limit_reg);
        nib_ok  = (ticks >= `SNR_NIB_MIN) && (ticks <= `SNR_NIB_MAX);
        val       = 4'(ticks - `SNR_NIB_MIN);
        crc_final = crc_step(crc, 4'h0);
        if (phase >= tick_period - 1'b1) begin
            next_phase = '0;
            next_ticks = (ticks == TICK_MAX) ? ticks : ticks + 1'b1;
        end
        if (fall) begin
            next_ivl   = {{(`SNR_CNT_W-1){1'b0}}, 1'b1};
            next_phase = tick_period >> 1;
            next_ticks = '0;
        end
        unique case (state)
            ST_IDLE: begin
                if (fall) begin
                    next_state = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (fall && sync_ok) begin
                    next_state        = ST_DATA;
                    next_sync_capture = ivl;
                    next_tick_period  = (tick_raw == '0) ?
                        {{(`SNR_CNT_W-1){1'b0}}, 1'b1} : tick_raw;
                    next_phase        = next_tick_period >> 1;
                    next_nib_idx      = 3'h0;
                    next_shift        = '0;
                    next_crc          = `SNR_CRC_SEED;
                end
            end
            ST_DATA: begin
                if (fall && !nib_ok) begin
                    next_state   = ST_HUNT;
                    next_nib_err = 1'b1;
                end else if (fall && nib_idx == last_idx) begin
                    if (hw_crc && crc_final != val) begin
                        next_state   = ST_HUNT;
                        next_crc_err = 1'b1;
                    end else begin
                        next_state = pause_on ? ST_PAUSE : ST_HUNT;
                        next_frame = {shift, val};
                        next_done  = 1'b1;
                    end
                end else if (fall) begin
                    next_nib_idx = nib_idx + 3'h1;
                    next_shift   = {shift[23:0], val};
                    if (nib_idx != 3'h0) begin
                        next_crc = crc_step(crc, val);
                    end
                end
            end
            ST_PAUSE: begin
                if (fall) begin
                    next_state = ST_HUNT;
                end
            end
        endcase
        if (!enable) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state               <= ST_IDLE;
            ivl                 <= '0;
            phase               <= '0;
            ticks               <= '0;
            nib_idx             <= '0;
            shift               <= '0;
            crc                 <= `SNR_CRC_SEED;
            sync_capture        <= '0;
            tick_period         <= {{(`SNR_CNT_W-1){1'b0}}, 1'b1};
            frame_data_high_low <= '0;
            message_done        <= 1'b0;
            nibble_error        <= 1'b0;
            crc_error           <= 1'b0;
            frame_active        <= 1'b0;
        end else begin
            state               <= next_state;
            ivl                 <= next_ivl;
            phase               <= next_phase;
            ticks               <= next_ticks;
            nib_idx             <= next_nib_idx;
            shift               <= next_shift;
            crc                 <= next_crc;
            sync_capture        <= next_sync_capture;
            tick_period         <= next_tick_period;
            frame_data_high_low <= next_frame;
            message_done        <= next_done;
            nibble_error        <= next_nib_err;
            crc_error           <= next_crc_err;
            frame_active        <= (next_state == ST_DATA);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_off_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !enable |=> state == ST_IDLE)
        else $error("engine active while receiver disabled");
    chk_sync_accept: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_HUNT && fall && sync_ok && enable
        |=> state == ST_DATA && sync_capture == $past(ivl))
        else $error("valid sync not accepted or captured");
    chk_sync_reject: assert property (@(posedge sys_clk) disable iff (rst)
        state == ST_HUNT && fall && !sync_ok
        |=> $stable(sync_capture) && !message_done && state != ST_DATA)
        else $error("out-of-limit interval taken as sync");
    chk_tick_derive: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(frame_active)
        |-> tick_period == ((sync_capture >> 3) == 0 ? 1 : sync_capture >> 3))
        else $error("tick period not derived from sync");
    chk_nibble_range: assert property (@(posedge sys_clk) disable iff (rst)
        nibble_error |-> $past(ticks) < `SNR_NIB_MIN
        || $past(ticks) > `SNR_NIB_MAX)
        else $error("nibble error on a valid width");
    chk_done_count: assert property (@(posedge sys_clk) disable iff (rst)
        message_done |-> $past(nib_idx) == $past(last_idx)
        && $past(state) == ST_DATA && $past(fall))
        else $error("completion without full frame");
    chk_pause_wait: assert property (@(posedge sys_clk) disable iff (rst)
        message_done && $past(pause_on) && $past(enable)
        |-> state == ST_PAUSE)
        else $error("pause pulse not expected");
    chk_crc_gate: assert property (@(posedge sys_clk) disable iff (rst)
        crc_error |-> $past(hw_crc) && !message_done)
        else $error("crc error raised with software crc");
endmodule

// ===== shared/snr_map.svh
// Purpose: constants of the nibble-link receiver
// Assumes: 40 MHz sys_clk
// Notes:   bit positions refer to the control_one word
`ifndef SNR_MAP_SVH
`define SNR_MAP_SVH

// ------------------------------------------------------------
// control_one fields
// ------------------------------------------------------------
`define SNR_ON_BIT      15
`define SNR_RCV_BIT     11
`define SNR_CRC_BIT     8
`define SNR_PPP_BIT     7
`define SNR_NIB_MSB     2
`define SNR_NIB_LSB     0

// ------------------------------------------------------------
// widths, timing and check values
// ------------------------------------------------------------
`define SNR_CNT_W       16
`define SNR_TICK_W      8
`define SNR_SYNC_SHIFT  4'h3
`define SNR_NIB_MIN     8'h0c
`define SNR_NIB_MAX     8'h1b
`define SNR_NIB_LO      3'h1
`define SNR_NIB_HI      3'h6
`define SNR_CRC_SEED    4'h5
`define SNR_CRC_POLY    4'hd

`endif

// ===== shared/snr_pkg.sv
// Purpose: types of the nibble-link receiver
// Assumes: snr_map.svh holds the numbers
// Notes:   none
package snr_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HUNT,
        ST_DATA,
        ST_PAUSE
    } snr_state_t;

    typedef struct packed {
        logic [15:0] frame_data_high;
        logic [15:0] frame_data_low;
    } snr_frame_t;

endpackage

// ===== logic/snr_edge_sync.sv
// Purpose: synchronise the line and flag its falling edges
// Assumes: line is asynchronous to sys_clk
// Notes:   a level counts once stages two and three agree
`include "snr_map.svh"
module snr_edge_sync
    import snr_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // line and event
    input  wire logic line_in,
    output logic      fall
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic level;
    logic next_level;
    logic next_fall;

    // ------------------------------------------------------------
    // settled level and edge
    // ------------------------------------------------------------
    always_comb begin
        next_level = (sync_b == sync_c) ? sync_c : level;
        next_fall  = level & (sync_b == sync_c) & ~sync_c;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            sync_c <= 1'b1;
            level  <= 1'b1;
            fall   <= 1'b0;
        end else begin
            sync_a <= line_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
            level  <= next_level;
            fall   <= next_fall;
        end
    end
endmodule

// ===== verif/snr_sensor_model.sv
// Purpose: sensor side of the nibble link
// Assumes: called by the bench just after a rising edge
// Notes:   line idles high, as with the pull-up of the real wire
module snr_sensor_model (
    // clock
    input  wire logic sys_clk,
    // line
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial line_out = 1'b1;

    // one interval: fall, four ticks low, high until the next fall
    task automatic send_interval(input int tk, input int ticks);
        line_out <= 1'b0;
        repeat (4 * tk) @(posedge sys_clk);
        line_out <= 1'b1;
        repeat ((ticks - 4) * tk) @(posedge sys_clk);
    endtask
endmodule

// ===== verif/test_snr_receiver.sv
// Purpose: self-checking bench of the nibble-link receiver
// Assumes: 40 MHz sys_clk, frames sent by the sensor model
// Notes:   expectations are rebuilt from limits and config
`include "snr_map.svh"
module test_snr_receiver
    import snr_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [15:0] cfg;
        int          tk;
        logic [3:0]  st;
        logic [23:0] d;
        int          err;
    } snr_row_t;

    logic        sys_clk;
    logic        rst;
    logic        line;
    logic [15:0] control_one;
    logic [15:0] upper_limit_reg;
    logic [15:0] lower_limit_reg;
    logic [15:0] sync_capture;
    logic [15:0] tick_period;
    snr_frame_t  frame;
    logic        message_done;
    logic        nibble_error;
    logic        crc_error;
    logic        frame_active;
    int          fails;
    int          total_checks;
    int          n_done;
    int          n_nib;
    int          n_crc;
    logic [31:0] got_frame;
    logic [31:0] exp_frame;
    logic [15:0] exp_sync;

    snr_row_t rows [10] = '{
        '{16'h8801, 8, 4'h3, 24'ha00000, 0},
        '{16'h8902, 8, 4'h0, 24'h5c0000, 0},
        '{16'h8903, 8, 4'hf, 24'h0f9000, 0},
        '{16'h8984, 8, 4'h1, 24'h7e21bb, 0},
        '{16'h8905, 8, 4'h8, 24'h13579b, 0},
        '{16'h8906, 8, 4'h6, 24'hfedcba, 0},
        '{16'h8900, 8, 4'h4, 24'h900000, 0},
        '{16'h8907, 9, 4'h2, 24'h024681, 0},
        '{16'h8886, 8, 4'ha, 24'h314159, 0},
        '{16'h8802, 8, 4'h5, 24'h690000, 1}
    };

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    snr_receiver dut (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .line_in            (line),
        .control_one        (control_one),
        .upper_limit_reg    (upper_limit_reg),
        .lower_limit_reg    (lower_limit_reg),
        .sync_capture       (sync_capture),
        .tick_period        (tick_period),
        .frame_data_high_low(frame),
        .message_done       (message_done),
        .nibble_error       (nibble_error),
        .crc_error          (crc_error),
        .frame_active       (frame_active)
    );

    snr_sensor_model sensor (
        .sys_clk (sys_clk),
        .line_out(line)
    );

    // ------------------------------------------------------------
    // pulse counters, frame taken at completion
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (message_done === 1'b1) begin
            n_done++;
            got_frame = frame;
        end
        if (nibble_error === 1'b1) n_nib++;
        if (crc_error === 1'b1) n_crc++;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [3:0] crc4(input logic [23:0] d, input int n);
        logic [3:0] c;
        logic [3:0] q;
        logic       top;
        c = `SNR_CRC_SEED;
        for (int i = 0; i <= n; i++) begin
            q = (i < n) ? d[23 - 4 * i -: 4] : 4'h0;
            for (int b = 3; b >= 0; b--) begin
                top = c[3];
                c = {c[2:0], q[b]};
                if (top) c = c ^ `SNR_CRC_POLY;
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // one configured run: frame(s), closing gap, then compare
    // ------------------------------------------------------------
    task automatic run(input snr_row_t r);
        int          n;
        int          frames;
        int          nd;
        int          nn;
        int          nc;
        logic [3:0]  c;
        logic [31:0] w;
        logic        ok;
        n = (r.cfg[2:0] == 3'h0) ? 1 : (r.cfg[2:0] == 3'h7) ? 6 : 0;
        if (n == 0) n = int'(r.cfg[2:0]);
        frames = r.cfg[`SNR_PPP_BIT] ? 2 : 1;
        c = crc4(r.d, n) ^ ((r.err == 1) ? 4'h1 : 4'h0);
        w = {28'h0, r.st};
        for (int i = 0; i < n; i++) w = {w[27:0], r.d[23 - 4 * i -: 4]};
        w = {w[27:0], c};
        nd = n_done;
        nn = n_nib;
        nc = n_crc;
        control_one <= r.cfg & 16'h7fff;
        @(posedge sys_clk);
        control_one <= r.cfg;
        @(posedge sys_clk);
        repeat (frames) begin
            sensor.send_interval(r.tk, 8);
            sensor.send_interval(r.tk, 12 + int'(r.st));
            for (int i = 0; i < n; i++) begin
                sensor.send_interval(r.tk, (r.err == 2 && i == 0) ? 11 :
                                     12 + int'(r.d[23 - 4 * i -: 4]));
            end
            sensor.send_interval(r.tk, 12 + int'(c));
            if (frames == 2) sensor.send_interval(r.tk, 20);
        end
        sensor.send_interval(r.tk, 30);
        ok = r.cfg[15] && r.cfg[`SNR_RCV_BIT] && (r.tk * 8 >= lower_limit_reg)
             && (r.tk * 8 <= upper_limit_reg);
        if (ok && r.err == 2) begin
            nn += frames;
        end else if (ok && r.err == 1 && r.cfg[`SNR_CRC_BIT]) begin
            nc += frames;
        end else if (ok) begin
            nd += frames;
            exp_frame = w;
            exp_sync = 16'(r.tk * 8);
        end
        check("done count", n_done, nd);
        check("nibble errors", n_nib, nn);
        check("crc errors", n_crc, nc);
        check("frame", got_frame, exp_frame);
        check("sync capture", sync_capture, exp_sync);
        check("tick period", tick_period, exp_sync >> 3);
        check("frame active", frame_active, 32'h0);
        $display("test done cfg %h tick %0d", r.cfg, r.tk);
    endtask

    initial begin
        control_one = 16'h0;
        upper_limit_reg = 16'h004c;
        lower_limit_reg = 16'h0033;
        rst = 1'b1;
        got_frame = 32'h0;
        exp_frame = 32'h0;
        exp_sync = 16'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("reset sync", sync_capture, 32'h0);
        check("reset tick", tick_period, 32'h1);
        check("reset frame", frame, 32'h0);
        check("reset done", message_done, 32'h0);
        $display("test done reset");
        @(posedge sys_clk);
        foreach (rows[i]) run(rows[i]);
        run(snr_row_t'{16'h8103, 8, 4'h2, 24'h123456, 0});
        run(snr_row_t'{16'h8903, 10, 4'h2, 24'h123456, 0});
        run(snr_row_t'{16'h8903, 8, 4'h2, 24'h123456, 2});
        run(snr_row_t'{16'h8903, 8, 4'h2, 24'h123456, 1});
        upper_limit_reg <= 16'h0040;
        lower_limit_reg <= 16'h003f;
        @(posedge sys_clk);
        run(snr_row_t'{16'h8902, 8, 4'h9, 24'h3c0000, 0});
        run(snr_row_t'{16'h8902, 9, 4'h9, 24'h3c0000, 0});
        upper_limit_reg <= 16'h004c;
        lower_limit_reg <= 16'h0033;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("mid reset sync", sync_capture, 32'h0);
        check("mid reset tick", tick_period, 32'h1);
        check("mid reset frame", frame, 32'h0);
        check("mid reset active", frame_active, 32'h0);
        $display("test done mid-run reset");
        @(posedge sys_clk);
        run(rows[0]);
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        $display("unexpected watchdog expired");
        print_verdict();
    end
endmodule
